// File: hw/eir_cfg.svh
// Purpose: Constants of the error and interrupt routing block
// Assumes: Included by the package, by eir_top, by eir_properties and by tb_top
// Notes:   Vectors are vector table offsets, levels are priority levels
`ifndef EIR_CFG_SVH
`define EIR_CFG_SVH

// Field widths
`define EIR_CODE_W   8
`define EIR_VEC_W    12
`define EIR_IPL_W    5
`define EIR_DIRQ_W   4

// Vector table entries
`define EIR_VEC_MCHK 12'h004
`define EIR_VEC_SOFT 12'h054
`define EIR_VEC_HARD 12'h060

// Priority levels
`define EIR_IPL_MCHK 5'h1F
`define EIR_IPL_HARD 5'h1D
`define EIR_IPL_SOFT 5'h1A
`define EIR_IPL_DEV0 5'h14

// Bit positions in the pending vector
`define EIR_K_MCHK   0
`define EIR_K_HARD   1
`define EIR_K_SOFT   2
`define EIR_K_N      3

// Reset values
`define EIR_RST_CODE 8'h00
`define EIR_RST_PEND 3'h0
`define EIR_RST_DIRQ 4'h0

`endif

// File: hw/eir_pkg.sv
// Purpose: Types of the error and interrupt routing block
// Assumes: eir_cfg.svh holds the widths
// Notes:   No constants live here, only types
`include "eir_cfg.svh"

package eir_pkg;

  typedef enum logic [1:0] {
    eir_sev_none,
    eir_sev_soft,
    eir_sev_hard,
    eir_sev_mchk
  } eir_sev_type;

  typedef enum logic [1:0] {
    eir_src_core,
    eir_src_memctl,
    eir_src_adapter,
    eir_src_io
  } eir_src_type;

  typedef enum logic [1:0] {
    eir_kind_mchk,
    eir_kind_hard,
    eir_kind_soft
  } eir_kind_type;

  typedef struct packed {
    logic                     valid;
    logic                     dma;
    eir_sev_type              sev;
    logic [`EIR_CODE_W-1:0]   code;
  } eir_err_type;

  typedef struct packed {
    logic                     valid;
    eir_kind_type             kind;
    eir_src_type              src;
    logic [`EIR_VEC_W-1:0]    vector;
    logic [`EIR_IPL_W-1:0]    interrupt_priority_level;
  } eir_core_req_type;

  typedef struct packed {
    logic                     valid;
    logic                     from_memctl;
    logic                     from_adapter;
    logic [`EIR_CODE_W-1:0]   code;
  } eir_dma_ret_type;

endpackage : eir_pkg

// File: hw/eir_sticky.sv
// Purpose: Bank of sticky flags, set by hardware, cleared by software
// Assumes: set and clear come from logic on clk_sys
// Notes:   A set in the cycle of a clear wins
`timescale 1ns/1ps
`default_nettype none

module eir_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // Per bit set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clear,
  // Held flags
  output logic      [W-1:0] state
);

  logic [W-1:0] next_state;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always_comb
      begin
        // Held until cleared; a fresh event overrides the clear
        next_state[i] = (state[i] & ~clear[i]) | set[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0;
    else
      state <= next_state;
  end

endmodule : eir_sticky

`default_nettype wire

// File: hw/eir_top.sv
// Purpose: Routes error reports into machine checks, error interrupts
//          or returns to the requesting device, and latches error state
// Assumes: All reports come from logic on clk_sys, one-cycle pulses
// Notes:   Machine check outranks hard, hard outranks soft
//
// Contract
// - A core-internal error raises a machine check at entry 004 or a soft interrupt at 1A, 054.
// - An error seen by the memory controller or bus adapter outside the core is posted to it.
// - A posted external error becomes a machine check 004, hard interrupt 1D 060, or soft 054.
// - The bus adapter posts an io side device error to the core as machine check or interrupt.
// - A DMA error found by adapter or memory controller returns to the device, not the core.
// - Memory controller and bus adapter latch detected error state for later reading.
`timescale 1ns/1ps
`default_nettype none
`include "eir_cfg.svh"

module eir_top #(
  parameter int CODE_W = `EIR_CODE_W
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  // Error reports
  input  wire eir_pkg::eir_err_type      core_err,
  input  wire eir_pkg::eir_err_type      memctl_err,
  input  wire eir_pkg::eir_err_type      adapter_err,
  input  wire eir_pkg::eir_err_type      io_dev_err,
  // Request to the core
  output eir_pkg::eir_core_req_type      core_req,
  input  wire logic                      core_ack,
  // DMA error return to the io side bus
  output eir_pkg::eir_dma_ret_type       dma_ret,
  // Device level interrupts, levels 14 to 17
  input  wire logic [`EIR_DIRQ_W-1:0]    dev_irq_in,
  output logic      [`EIR_DIRQ_W-1:0]    dev_irq_out,
  // Latched state for polling
  output logic      [CODE_W-1:0]         memctl_state,
  output logic      [CODE_W-1:0]         adapter_state,
  output logic      [1:0]                polled_state,
  output logic      [`EIR_K_N-1:0]       overrun_state,
  // Software clears
  input  wire logic [CODE_W-1:0]         memctl_clear,
  input  wire logic [CODE_W-1:0]         adapter_clear,
  input  wire logic [1:0]                polled_clear,
  input  wire logic [`EIR_K_N-1:0]       overrun_clear
);

  typedef enum logic {
    st_idle,
    st_post
  } eir_state_type;

  eir_state_type              state;
  eir_state_type              next_state;
  logic [`EIR_K_N-1:0]        pend;
  logic [`EIR_K_N-1:0]        next_pend;
  logic [`EIR_K_N-1:0]        set_pend;
  logic [`EIR_K_N-1:0]        clr_pend;
  eir_pkg::eir_src_type       src [`EIR_K_N];
  eir_pkg::eir_src_type       next_src [`EIR_K_N];
  eir_pkg::eir_core_req_type  next_req;
  eir_pkg::eir_dma_ret_type   next_ret;
  logic [`EIR_DIRQ_W-1:0]     next_dirq;
  logic [CODE_W-1:0]          memctl_set;
  logic [CODE_W-1:0]          adapter_set;
  logic [1:0]                 polled_set;
  logic [`EIR_K_N-1:0]        overrun_set;
  logic                       mem_post;
  logic                       ada_post;
  logic                       io_post;

  // A report that goes to the core: non-DMA, with a severity
  function automatic logic eir_posts(input eir_pkg::eir_err_type e);
    eir_posts = e.valid & ~e.dma & (e.sev != eir_pkg::eir_sev_none);
  endfunction : eir_posts

  // Events into pending kinds
  always_comb
  begin
    mem_post = eir_posts(memctl_err);
    ada_post = eir_posts(adapter_err);
    // Errors of core transactions on the io side arrive via the adapter
    io_post  = io_dev_err.valid & (io_dev_err.sev != eir_pkg::eir_sev_none);
    set_pend = '0;
    // Core errors only take the machine check or soft path; hard maps up
    if (core_err.valid && core_err.sev != eir_pkg::eir_sev_none)
    begin
      if (core_err.sev == eir_pkg::eir_sev_soft)
        set_pend[`EIR_K_SOFT] = 1'b1;
      else
        set_pend[`EIR_K_MCHK] = 1'b1;
    end
    if (mem_post && memctl_err.sev == eir_pkg::eir_sev_mchk)
      set_pend[`EIR_K_MCHK] = 1'b1;
    if (mem_post && memctl_err.sev == eir_pkg::eir_sev_hard)
      set_pend[`EIR_K_HARD] = 1'b1;
    if (mem_post && memctl_err.sev == eir_pkg::eir_sev_soft)
      set_pend[`EIR_K_SOFT] = 1'b1;
    if (ada_post && adapter_err.sev == eir_pkg::eir_sev_mchk)
      set_pend[`EIR_K_MCHK] = 1'b1;
    if (ada_post && adapter_err.sev == eir_pkg::eir_sev_hard)
      set_pend[`EIR_K_HARD] = 1'b1;
    if (ada_post && adapter_err.sev == eir_pkg::eir_sev_soft)
      set_pend[`EIR_K_SOFT] = 1'b1;
    // High-level only: soft io reports are raised to hard
    if (io_post && io_dev_err.sev == eir_pkg::eir_sev_mchk)
      set_pend[`EIR_K_MCHK] = 1'b1;
    if (io_post && io_dev_err.sev != eir_pkg::eir_sev_mchk)
      set_pend[`EIR_K_HARD] = 1'b1;
  end

  // Source of each kind; the lowest-priority source is applied first
  always_comb
  begin
    for (int k = 0; k < `EIR_K_N; k++)
      next_src[k] = src[k];
    if (io_post)
      next_src[(io_dev_err.sev == eir_pkg::eir_sev_mchk) ? `EIR_K_MCHK : `EIR_K_HARD]
        = eir_pkg::eir_src_io;
    if (ada_post)
      next_src[(adapter_err.sev == eir_pkg::eir_sev_mchk) ? `EIR_K_MCHK :
               (adapter_err.sev == eir_pkg::eir_sev_hard) ? `EIR_K_HARD : `EIR_K_SOFT]
        = eir_pkg::eir_src_adapter;
    if (mem_post)
      next_src[(memctl_err.sev == eir_pkg::eir_sev_mchk) ? `EIR_K_MCHK :
               (memctl_err.sev == eir_pkg::eir_sev_hard) ? `EIR_K_HARD : `EIR_K_SOFT]
        = eir_pkg::eir_src_memctl;
    if (core_err.valid && core_err.sev != eir_pkg::eir_sev_none)
      next_src[(core_err.sev == eir_pkg::eir_sev_soft) ? `EIR_K_SOFT : `EIR_K_MCHK]
        = eir_pkg::eir_src_core;
  end

  // Posting machine: one request at a time, held until the core takes it
  always_comb
  begin
    next_state = state;
    next_req   = core_req;
    clr_pend   = '0;
    case (state)
      st_idle:
      begin
        if (pend[`EIR_K_MCHK])
        begin
          next_req.kind   = eir_pkg::eir_kind_mchk;
          next_req.src    = src[`EIR_K_MCHK];
          next_req.vector = `EIR_VEC_MCHK;
          next_req.interrupt_priority_level    = `EIR_IPL_MCHK;
        end
        else if (pend[`EIR_K_HARD])
        begin
          next_req.kind   = eir_pkg::eir_kind_hard;
          next_req.src    = src[`EIR_K_HARD];
          next_req.vector = `EIR_VEC_HARD;
          next_req.interrupt_priority_level    = `EIR_IPL_HARD;
        end
        else
        begin
          next_req.kind   = eir_pkg::eir_kind_soft;
          next_req.src    = src[`EIR_K_SOFT];
          next_req.vector = `EIR_VEC_SOFT;
          next_req.interrupt_priority_level    = `EIR_IPL_SOFT;
        end
        next_req.valid = |pend;
        if (|pend)
          next_state = st_post;
      end
      st_post:
      begin
        if (core_ack)
        begin
          clr_pend[core_req.kind] = 1'b1;
          next_req.valid          = 1'b0;
          next_state              = st_idle;
        end
      end
      default:
      begin
        next_req.valid = 1'b0;
        next_state     = st_idle;
      end
    endcase
    // A new event of the kind being acknowledged stays pending
    next_pend   = (pend & ~clr_pend) | set_pend;
    overrun_set = set_pend & pend & ~clr_pend;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= st_idle;
      pend     <= `EIR_RST_PEND;
      core_req <= '0;
      for (int k = 0; k < `EIR_K_N; k++)
        src[k] <= eir_pkg::eir_src_core;
    end
    else
    begin
      state    <= next_state;
      pend     <= next_pend;
      core_req <= next_req;
      for (int k = 0; k < `EIR_K_N; k++)
        src[k] <= next_src[k];
    end
  end

  // DMA returns and device interrupt forwarding
  always_comb
  begin
    next_ret.from_memctl  = memctl_err.valid & memctl_err.dma;
    next_ret.from_adapter = adapter_err.valid & adapter_err.dma;
    next_ret.valid        = next_ret.from_memctl | next_ret.from_adapter;
    next_ret.code         = (next_ret.from_memctl ? memctl_err.code : `EIR_RST_CODE)
                          | (next_ret.from_adapter ? adapter_err.code : `EIR_RST_CODE);
    // The device answers a DMA error with its own interrupt via the adapter
    next_dirq             = dev_irq_in;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dma_ret     <= '0;
      dev_irq_out <= `EIR_RST_DIRQ;
    end
    else
    begin
      dma_ret     <= next_ret;
      dev_irq_out <= next_dirq;
    end
  end

  // Latched error state; DMA errors also mark the polled flags
  always_comb
  begin
    memctl_set  = memctl_err.valid ? memctl_err.code : `EIR_RST_CODE;
    adapter_set = (adapter_err.valid ? adapter_err.code : `EIR_RST_CODE)
                | (io_dev_err.valid ? io_dev_err.code : `EIR_RST_CODE);
    // No error interrupt reaches the core for these, so software must find them by polling
    polled_set  = {next_ret.from_adapter, next_ret.from_memctl};
  end

  eir_sticky #(.W(CODE_W)) u_memctl_state (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .set     (memctl_set),
    .clear   (memctl_clear),
    .state   (memctl_state)
  );

  eir_sticky #(.W(CODE_W)) u_adapter_state (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .set     (adapter_set),
    .clear   (adapter_clear),
    .state   (adapter_state)
  );

  eir_sticky #(.W(2)) u_polled_state (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .set     (polled_set),
    .clear   (polled_clear),
    .state   (polled_state)
  );

  // Overrun marks a second event of a kind merged into one request
  eir_sticky #(.W(`EIR_K_N)) u_overrun_state (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .set     (overrun_set),
    .clear   (overrun_clear),
    .state   (overrun_state)
  );

endmodule : eir_top

`default_nettype wire

// File: bench/eir_properties.sv
// Purpose: Port timing checks of eir_top
// Assumes: Reports are one-cycle pulses on clk_sys
// Notes:   LAT leaves room for a slow core behind other kinds
`timescale 1ns/1ps
`default_nettype none
`include "eir_cfg.svh"

module eir_properties #(
  parameter int CODE_W = 8
) (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      arst_n,
  // Reports and answers
  input wire eir_pkg::eir_err_type      core_err,
  input wire eir_pkg::eir_err_type      memctl_err,
  input wire eir_pkg::eir_err_type      io_dev_err,
  input wire eir_pkg::eir_core_req_type core_req,
  input wire logic                      core_ack,
  input wire eir_pkg::eir_dma_ret_type  dma_ret,
  // Latched state
  input wire logic [CODE_W-1:0]         memctl_state,
  input wire logic [CODE_W-1:0]         memctl_clear
);
  localparam int LAT = 40;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_mchk_entry : assert property (
    core_req.valid && core_req.kind == eir_pkg::eir_kind_mchk
    |-> core_req.vector == `EIR_VEC_MCHK && core_req.interrupt_priority_level == `EIR_IPL_MCHK)
    else $error("machine check entry wrong");
  chk_hard_entry : assert property (
    core_req.valid && core_req.kind == eir_pkg::eir_kind_hard
    |-> core_req.vector == `EIR_VEC_HARD && core_req.interrupt_priority_level == `EIR_IPL_HARD)
    else $error("hard interrupt entry wrong");
  chk_soft_entry : assert property (
    core_req.valid && core_req.kind == eir_pkg::eir_kind_soft
    |-> core_req.vector == `EIR_VEC_SOFT && core_req.interrupt_priority_level == `EIR_IPL_SOFT)
    else $error("soft interrupt entry wrong");
  chk_core_soft : assert property (
    core_err.valid && core_err.sev == eir_pkg::eir_sev_soft
    |-> ##[1:LAT] core_req.valid && core_req.kind == eir_pkg::eir_kind_soft)
    else $error("core soft error not raised");
  chk_io_post : assert property (
    io_dev_err.valid && io_dev_err.sev == eir_pkg::eir_sev_soft
    |-> ##[1:LAT] core_req.valid && core_req.kind == eir_pkg::eir_kind_hard)
    else $error("device error not posted as hard");
  chk_dma_return : assert property (
    memctl_err.valid && memctl_err.dma |=> dma_ret.valid && dma_ret.from_memctl)
    else $error("dma error not returned");
  chk_req_hold : assert property (
    core_req.valid && !core_ack |=> core_req.valid && $stable(core_req.kind))
    else $error("request dropped before ack");
  chk_ack_drop : assert property (
    core_req.valid && core_ack |=> !core_req.valid)
    else $error("request kept after ack");
  chk_latch_set : assert property (
    memctl_err.valid |=> (memctl_state & $past(memctl_err.code)) == $past(memctl_err.code))
    else $error("error code not latched");
  chk_latch_hold : assert property (
    memctl_clear == '0 |=> (memctl_state & $past(memctl_state)) == $past(memctl_state))
    else $error("latched state lost without clear");

  cov_ack : cover property (core_req.valid && core_ack);
  cov_dma_both : cover property (dma_ret.valid && dma_ret.from_memctl && dma_ret.from_adapter);
  cov_clear : cover property (memctl_state != '0 && memctl_clear != '0);
endmodule : eir_properties

bind eir_top eir_properties #(.CODE_W(CODE_W)) i_eir_properties (
  .clk_sys(clk_sys), .arst_n(arst_n), .core_err(core_err), .memctl_err(memctl_err),
  .io_dev_err(io_dev_err), .core_req(core_req), .core_ack(core_ack), .dma_ret(dma_ret),
  .memctl_state(memctl_state), .memctl_clear(memctl_clear));
`default_nettype wire

// File: bench/eir_partner.sv
// Purpose: Core and io side device model for eir_top
// Assumes: Ack follows ack_wait cycles of a presented request
// Notes:   Device holds level 14 after a dma return until irq_clr
`timescale 1ns/1ps
`default_nettype none

module eir_partner (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  // Core side
  input  wire eir_pkg::eir_core_req_type core_req,
  input  wire logic [3:0]                ack_wait,
  output var  logic                      core_ack,
  output var  eir_pkg::eir_core_req_type last_req,
  output var  logic [7:0]                taken,
  // Device side
  input  wire eir_pkg::eir_dma_ret_type  dma_ret,
  input  wire logic                      irq_clr,
  output var  logic [3:0]                dev_irq
);
  logic [3:0] cnt;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_ack <= 1'b0;
      last_req <= '0;
      taken    <= 8'h00;
      cnt      <= 4'h0;
      dev_irq  <= 4'h0;
    end
    else
    begin
      if (core_ack)
      begin
        core_ack <= 1'b0;
        cnt      <= 4'h0;
        last_req <= core_req;
        taken    <= taken + 8'h01;
      end
      else if (core_req.valid && cnt >= ack_wait)
        core_ack <= 1'b1;
      else if (core_req.valid)
        cnt <= cnt + 4'h1;
      // A device hit by a dma error asks for service at level 14
      if (dma_ret.valid)
        dev_irq[0] <= 1'b1;
      else if (irq_clr)
        dev_irq <= 4'h0;
    end
  end
endmodule : eir_partner
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench of eir_top
// Assumes: eir_partner plays the core and the io side device
// Notes:   Expected codes are tracked here, never read back
`timescale 1ns/1ps
`default_nettype none
`include "eir_cfg.svh"

module tb_top;
  logic                      clk_sys = 1'b0;
  logic                      arst_n  = 1'b0;
  eir_pkg::eir_err_type      e [4];
  eir_pkg::eir_core_req_type core_req;
  eir_pkg::eir_core_req_type last_req;
  eir_pkg::eir_dma_ret_type  dma_ret;
  logic                      core_ack;
  logic                      irq_clr;
  logic [3:0]                ack_wait, dev_irq, dev_out;
  logic [7:0]                taken, m_st, a_st, m_clr, a_clr, exp_m, exp_a;
  logic [1:0]                p_st, p_clr;
  logic [2:0]                o_st, o_clr;
  int                        errors, cmp_count, cyc;

  always #50 clk_sys = ~clk_sys;

  eir_top i_eir_top (.clk_sys(clk_sys), .arst_n(arst_n), .core_err(e[0]),
    .memctl_err(e[1]), .adapter_err(e[2]), .io_dev_err(e[3]), .core_req(core_req),
    .core_ack(core_ack), .dma_ret(dma_ret), .dev_irq_in(dev_irq), .dev_irq_out(dev_out),
    .memctl_state(m_st), .adapter_state(a_st), .polled_state(p_st), .overrun_state(o_st),
    .memctl_clear(m_clr), .adapter_clear(a_clr), .polled_clear(p_clr), .overrun_clear(o_clr));
  eir_partner i_eir_partner (.clk_sys(clk_sys), .arst_n(arst_n), .core_req(core_req),
    .ack_wait(ack_wait), .core_ack(core_ack), .last_req(last_req), .taken(taken),
    .dma_ret(dma_ret), .irq_clr(irq_clr), .dev_irq(dev_irq));

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Hang guard, about fifteen times the normal run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      $display("FAIL %0t run limit reached", $time);
      end_of_test;
    end
  end

  task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp_bits

  // Lets the edge's updates land before looking
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic send(input int i, input eir_pkg::eir_sev_type s, input logic d,
                      input logic [7:0] c, input int n);
    @(posedge clk_sys);
    e[i] <= '{1'b1, d, s, c};
    repeat (n) @(posedge clk_sys);
    e[i].valid <= 1'b0;
  endtask : send

  task automatic route(input int i, input eir_pkg::eir_sev_type s,
                       input eir_pkg::eir_kind_type k, input logic [11:0] v, input logic [4:0] l);
    logic [7:0] n0;
    logic [7:0] c;
    n0 = taken;
    c  = 8'h01 << {i[1:0], s[0]};
    send(i, s, 1'b0, c, 1);
    if (i == 1)
      exp_m |= c;
    else if (i > 1)
      exp_a |= c;
    for (int w = 0; w < 40 && taken == n0; w++)
      tick();
    cmp_bits({last_req.kind, last_req.src, last_req.vector, last_req.interrupt_priority_level},
             {k, eir_pkg::eir_src_type'(i), v, l});
  endtask : route

  task automatic t_reset;
    tick();
    cmp_bits({core_req.valid, dma_ret.valid, m_st, a_st, p_st, o_st, dev_out}, 32'h0);
  endtask : t_reset

  task automatic t_post;
    route(0, eir_pkg::eir_sev_soft, eir_pkg::eir_kind_soft, 12'h054, 5'h1A);
    route(0, eir_pkg::eir_sev_mchk, eir_pkg::eir_kind_mchk, 12'h004, 5'h1F);
    route(1, eir_pkg::eir_sev_hard, eir_pkg::eir_kind_hard, 12'h060, 5'h1D);
    @(posedge clk_sys);
    ack_wait <= 4'h5;
    route(1, eir_pkg::eir_sev_mchk, eir_pkg::eir_kind_mchk, 12'h004, 5'h1F);
    route(2, eir_pkg::eir_sev_soft, eir_pkg::eir_kind_soft, 12'h054, 5'h1A);
    route(3, eir_pkg::eir_sev_soft, eir_pkg::eir_kind_hard, 12'h060, 5'h1D);
    route(3, eir_pkg::eir_sev_mchk, eir_pkg::eir_kind_mchk, 12'h004, 5'h1F);
    route(0, eir_pkg::eir_sev_hard, eir_pkg::eir_kind_mchk, 12'h004, 5'h1F);
    route(1, eir_pkg::eir_sev_soft, eir_pkg::eir_kind_soft, 12'h054, 5'h1A);
    route(2, eir_pkg::eir_sev_hard, eir_pkg::eir_kind_hard, 12'h060, 5'h1D);
    route(2, eir_pkg::eir_sev_mchk, eir_pkg::eir_kind_mchk, 12'h004, 5'h1F);
    cmp_bits({m_st, a_st}, {exp_m, exp_a});
  endtask : t_post

  task automatic t_dma;
    logic [7:0] n0;
    n0 = taken;
    @(posedge clk_sys);
    e[1] <= '{1'b1, 1'b1, eir_pkg::eir_sev_hard, 8'h30};
    e[2] <= '{1'b1, 1'b1, eir_pkg::eir_sev_soft, 8'h0C};
    @(posedge clk_sys);
    e[1].valid <= 1'b0;
    e[2].valid <= 1'b0;
    exp_m |= 8'h30;
    exp_a |= 8'h0C;
    #1;
    cmp_bits({dma_ret.valid, dma_ret.from_memctl, dma_ret.from_adapter, dma_ret.code},
             {3'b111, 8'h3C});
    cmp_bits(p_st, 2'b11);
    tick();
    cmp_bits(dma_ret.valid, 1'b0);
    repeat (2) tick();
    cmp_bits(dev_out, 4'h1);
    repeat (10) tick();
    cmp_bits({taken, core_req.valid}, {n0, 1'b0});
    cmp_bits({m_st, a_st}, {exp_m, exp_a});
    @(posedge clk_sys);
    irq_clr <= 1'b1;
  endtask : t_dma

  task automatic t_clear;
    repeat (20) tick();
    cmp_bits({m_st, p_st}, {exp_m, 2'b11});
    @(posedge clk_sys);
    irq_clr <= 1'b0;
    m_clr <= 8'hFF;
    p_clr <= 2'h3;
    @(posedge clk_sys);
    m_clr <= 8'h00;
    p_clr <= 2'h0;
    #1;
    cmp_bits({m_st, p_st, a_st, dev_out}, {10'h0, exp_a, 4'h0});
    // Partial clear: bits outside the mask must survive
    @(posedge clk_sys);
    a_clr <= 8'hF0;
    @(posedge clk_sys);
    a_clr <= 8'h00;
    exp_a &= 8'h0F;
    #1;
    cmp_bits(a_st, exp_a);
  endtask : t_clear

  task automatic t_over;
    @(posedge clk_sys);
    ack_wait <= 4'h8;
    send(0, eir_pkg::eir_sev_soft, 1'b0, 8'h00, 3);
    repeat (40) tick();
    cmp_bits({o_st, core_req.valid}, {3'b100, 1'b0});
    @(posedge clk_sys);
    o_clr <= 3'h7;
    @(posedge clk_sys);
    o_clr <= 3'h0;
    #1;
    cmp_bits(o_st, 3'b000);
  endtask : t_over

  initial
  begin
    foreach (e[k])
      e[k] = '0;
    {m_clr, a_clr, p_clr, o_clr, irq_clr, ack_wait} = '0;
    {exp_m, exp_a} = '0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_post();
    t_dma();
    t_clear();
    t_over();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
